// ### logic/iep_params.svh
// Purpose: offsets, field positions and reset values of the enable block
// Assumes: register index times four gives the Avalon byte address
// Notes: definitions only
`ifndef IEP_PARAMS_SVH
`define IEP_PARAMS_SVH

// byte address width on the slave port
`define IEP_ADDR_W 14

// register indices (byte address = index * 4)
`define IEP_IDX_G0_ENL 12'hFC2
`define IEP_IDX_G1_ENH 12'hFC4
`define IEP_IDX_G1_ENL 12'hFC5
`define IEP_IDX_G2_ENH 12'hFC7
`define IEP_IDX_G0_REQ 12'hFD0
`define IEP_IDX_G1_REQ 12'hFD1
`define IEP_IDX_G2_REQ 12'hFD2
`define IEP_IDX_CTRL 12'hFD3
`define IEP_IDX_VEC 12'hFD4

// reset values
`define IEP_RST_ENABLE 8'h00
`define IEP_RST_REQ 8'h00

// field positions
`define IEP_DAC_MASK 8'h40
`define IEP_CTRL_GIE_BIT 0
`define IEP_SEL_BITS 5
`define IEP_LVL_GROUP0 2'h1
`define IEP_LVL_GROUP2 2'h2

`endif

// ### logic/iep_pkg.sv
// Purpose: types shared by the enable and priority block
// Assumes: nothing beyond the params header
// Notes: all state of the top lives in one packed struct
`default_nettype none

package iep_pkg;

    typedef enum logic [1:0] {
        BUS_IDLE = 2'b01,
        BUS_ACK = 2'b10
    } iep_bus_st_t;

    typedef struct packed {
        iep_bus_st_t st;
        logic wait_req;
        logic [31:0] rdata;
        logic [7:0] g0_enl;
        logic [7:0] g1_enh;
        logic [7:0] g1_enl;
        logic [7:0] g2_enh;
        logic [7:0] req0;
        logic [7:0] req1;
        logic [7:0] req2;
        logic gie;
        logic irq;
        logic [1:0] vec_grp;
        logic [2:0] vec_bit;
        logic [1:0] vec_lvl;
    } iep_state_t;

endpackage : iep_pkg

`default_nettype wire

// ### logic/iep_level.sv
// Purpose: best pending source of one request group
// Assumes: level is {high enable, low enable} of a pending source
// Notes: combinational, no state
`timescale 1ns/100ps
`default_nettype none

module iep_level #(
    parameter int W = 8
) (
    // enables and requests
    input wire logic [W-1:0] en_hi,
    input wire logic [W-1:0] en_lo,
    input wire logic [W-1:0] pend,
    // winner
    output logic [1:0] lvl,
    output logic [2:0] idx
);

    always_comb begin
        logic [1:0] l;
        l = 2'h0;
        lvl = 2'h0;
        idx = 3'h0;
        for (int i = 0; i < W; i++) begin
            // 00 off, 01 level 1, 10 level 2, 11 level 3
            l = pend[i] ? {en_hi[i], en_lo[i]} : 2'h0;
            // ascending scan with >=: higher bit wins a tie
            if (l != 2'h0 && l >= lvl) begin
                lvl = l;
                idx = 3'(i);
            end
        end
    end

endmodule : iep_level

`default_nettype wire

// ### logic/iep_regs.sv
// Purpose: interrupt enable and priority registers, request groups 0 to 2
// Assumes: Avalon-MM slave with waitrequest, 32-bit data, byte addresses
// Notes: source requests are sampled every cycle; a set beats a clear
//
// What this block does
// - per source: both enables off disable, else level 1, 2 or 3
// - group 0 low enables: timers 2..0, serial rx/tx, usb, resume, two-wire
// - group 1 enables: spi b, dac, dma 1..0, adc, spi a, lcd, rtc
// - group 1 dac enable bit 6 is read-only, writes ignored
// - group 2 high enables: port A7..A5, shared A/D 4..0
// - group 2 bits 4..0 follow the port A or D source select
// - a presented request sets its request bit
// - global enable forwards vectored requests, else core polls
`timescale 1ns/100ps
`default_nettype none
`include "iep_params.svh"

module iep_regs (
    // clock and reset
    input wire logic REF_CLK,
    input wire logic RESET,
    // avalon-mm slave
    input wire logic [`IEP_ADDR_W-1:0] ADDRESS,
    input wire logic READ,
    input wire logic WRITE,
    input wire logic [3:0] BYTEENABLE,
    input wire logic [31:0] WRITEDATA,
    output logic [31:0] READDATA,
    output logic WAITREQUEST,
    // request sources
    input wire logic [7:0] G0_REQ,
    input wire logic [7:0] G1_REQ,
    input wire logic [7:0] G2_REQ,
    input wire logic [4:0] PORTD_REQ,
    input wire logic [4:0] PORTD_SEL,
    // vectored interrupt to the core
    output logic IRQ,
    output logic [1:0] VEC_GROUP,
    output logic [2:0] VEC_BIT,
    output logic [1:0] VEC_LEVEL
);

    ////////////////////////////////////////////////////////////////////////
    // state

    localparam iep_pkg::iep_state_t RST_STATE = '{
        st: iep_pkg::BUS_IDLE,
        wait_req: 1'b1,
        g0_enl: `IEP_RST_ENABLE,
        g1_enh: `IEP_RST_ENABLE,
        g1_enl: `IEP_RST_ENABLE,
        g2_enh: `IEP_RST_ENABLE,
        req0: `IEP_RST_REQ,
        req1: `IEP_RST_REQ,
        req2: `IEP_RST_REQ,
        default: '0
    };

    iep_pkg::iep_state_t s_q;
    iep_pkg::iep_state_t s_d;

    logic [11:0] word_idx;
    logic [1:0] lvl0;
    logic [1:0] lvl1;
    logic [1:0] lvl2;
    logic [2:0] idx0;
    logic [2:0] idx1;
    logic [2:0] idx2;

    assign word_idx = ADDRESS[`IEP_ADDR_W-1:2];

    ////////////////////////////////////////////////////////////////////////
    // per-group priority pick

    // group 0 high enables live outside this block: low-only gives level 1
    iep_level #(.W(8)) u_lvl0 (
        .en_hi(8'h00),
        .en_lo(s_q.g0_enl),
        .pend(s_q.req0),
        .lvl(lvl0),
        .idx(idx0)
    );

    iep_level #(.W(8)) u_lvl1 (
        .en_hi(s_q.g1_enh),
        .en_lo(s_q.g1_enl),
        .pend(s_q.req1),
        .lvl(lvl1),
        .idx(idx1)
    );

    // group 2 low enables live outside: high-only gives level 2
    iep_level #(.W(8)) u_lvl2 (
        .en_hi(s_q.g2_enh),
        .en_lo(8'h00),
        .pend(s_q.req2),
        .lvl(lvl2),
        .idx(idx2)
    );

    ////////////////////////////////////////////////////////////////////////
    // read mux

    function automatic logic [31:0] read_word(input logic [11:0] widx);
        logic [31:0] r;
        r = 32'h0000_0000;
        case (widx)
            `IEP_IDX_G0_ENL: r[7:0] = s_q.g0_enl;
            `IEP_IDX_G1_ENH: r[7:0] = s_q.g1_enh;
            `IEP_IDX_G1_ENL: r[7:0] = s_q.g1_enl;
            `IEP_IDX_G2_ENH: r[7:0] = s_q.g2_enh;
            `IEP_IDX_G0_REQ: r[7:0] = s_q.req0;
            `IEP_IDX_G1_REQ: r[7:0] = s_q.req1;
            `IEP_IDX_G2_REQ: r[7:0] = s_q.req2;
            `IEP_IDX_CTRL: r[`IEP_CTRL_GIE_BIT] = s_q.gie;
            `IEP_IDX_VEC: r[7:0] = {s_q.vec_lvl, s_q.vec_grp, s_q.vec_bit, s_q.irq};
            default: r = 32'h0000_0000;
        endcase
        return r;
    endfunction : read_word

    ////////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        logic [7:0] g2_src;
        logic [7:0] clr0;
        logic [7:0] clr1;
        logic [7:0] clr2;
        logic [1:0] best_lvl;
        logic [1:0] best_grp;
        logic [2:0] best_bit;
        g2_src = G2_REQ;
        clr0 = 8'h00;
        clr1 = 8'h00;
        clr2 = 8'h00;
        best_lvl = 2'h0;
        best_grp = 2'h0;
        best_bit = 3'h0;
        s_d = s_q;

        // bus handshake: answer one cycle after the request is seen
        unique case (s_q.st)
            iep_pkg::BUS_IDLE: begin
                if (READ || WRITE) begin
                    s_d.st = iep_pkg::BUS_ACK;
                    s_d.wait_req = 1'b0;
                    s_d.rdata = read_word(word_idx);
                end
            end
            iep_pkg::BUS_ACK: begin
                s_d.st = iep_pkg::BUS_IDLE;
                s_d.wait_req = 1'b1;
                // only byte lane 0 carries register data
                if (WRITE && BYTEENABLE[0]) begin
                    case (word_idx)
                        `IEP_IDX_G0_ENL: s_d.g0_enl = WRITEDATA[7:0];
                        `IEP_IDX_G1_ENH: begin
                            s_d.g1_enh = (WRITEDATA[7:0] & ~`IEP_DAC_MASK)
                                | (s_q.g1_enh & `IEP_DAC_MASK);
                        end
                        `IEP_IDX_G1_ENL: begin
                            s_d.g1_enl = (WRITEDATA[7:0] & ~`IEP_DAC_MASK)
                                | (s_q.g1_enl & `IEP_DAC_MASK);
                        end
                        `IEP_IDX_G2_ENH: s_d.g2_enh = WRITEDATA[7:0];
                        `IEP_IDX_G0_REQ: clr0 = WRITEDATA[7:0];
                        `IEP_IDX_G1_REQ: clr1 = WRITEDATA[7:0];
                        `IEP_IDX_G2_REQ: clr2 = WRITEDATA[7:0];
                        `IEP_IDX_CTRL: s_d.gie = WRITEDATA[`IEP_CTRL_GIE_BIT];
                        default: s_d.gie = s_q.gie;
                    endcase
                end
            end
            // an illegal code falls back to idle rather than hanging the bus
            default: begin
                s_d.st = iep_pkg::BUS_IDLE;
                s_d.wait_req = 1'b1;
            end
        endcase

        // shared lines: enable bit applies to whichever pin is selected
        for (int i = 0; i < `IEP_SEL_BITS; i++) begin
            g2_src[i] = PORTD_SEL[i] ? PORTD_REQ[i] : G2_REQ[i];
        end

        // sticky request bits, write one to clear, a new set wins
        s_d.req0 = (s_q.req0 & ~clr0) | G0_REQ;
        s_d.req1 = (s_q.req1 & ~clr1) | G1_REQ;
        s_d.req2 = (s_q.req2 & ~clr2) | g2_src;

        // cross-group pick; strict > keeps the lower group on a tie
        best_lvl = lvl0;
        best_grp = 2'h0;
        best_bit = idx0;
        if (lvl1 > best_lvl) begin
            best_lvl = lvl1;
            best_grp = 2'h1;
            best_bit = idx1;
        end
        if (lvl2 > best_lvl) begin
            best_lvl = lvl2;
            best_grp = 2'h2;
            best_bit = idx2;
        end

        // polled mode: request bits still collect, nothing is forwarded
        s_d.irq = s_q.gie && (best_lvl != 2'h0);
        s_d.vec_lvl = s_q.gie ? best_lvl : 2'h0;
        s_d.vec_grp = s_q.gie ? best_grp : 2'h0;
        s_d.vec_bit = s_q.gie ? best_bit : 3'h0;
    end

    always_ff @(posedge REF_CLK) begin
        if (RESET) begin
            s_q <= RST_STATE;
        end else begin
            s_q <= s_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs

    assign READDATA = s_q.rdata;
    assign WAITREQUEST = s_q.wait_req;
    assign IRQ = s_q.irq;
    assign VEC_GROUP = s_q.vec_grp;
    assign VEC_BIT = s_q.vec_bit;
    assign VEC_LEVEL = s_q.vec_lvl;

    ////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge REF_CLK);
    endclocking

    default disable iff (RESET);

    // shared-line source as the select sees it, for the checks only
    logic [4:0] sel_req;
    assign sel_req = (PORTD_SEL & PORTD_REQ) | (~PORTD_SEL & G2_REQ[4:0]);

    dac_read_only_a: assert property (
        !s_q.g1_enh[6] && !s_q.g1_enl[6]
    ) else $error("dac enable bit changed");

    g0_enable_write_a: assert property (
        (WRITE && !WAITREQUEST && BYTEENABLE[0] && word_idx == `IEP_IDX_G0_ENL)
        |=> s_q.g0_enl == $past(WRITEDATA[7:0])
    ) else $error("group 0 low enable not written");

    g1_enable_write_a: assert property (
        (WRITE && !WAITREQUEST && BYTEENABLE[0] && word_idx == `IEP_IDX_G1_ENH)
        |=> s_q.g1_enh == ($past(WRITEDATA[7:0]) & ~`IEP_DAC_MASK)
    ) else $error("group 1 high enable not written");

    g1_low_write_a: assert property (
        (WRITE && !WAITREQUEST && BYTEENABLE[0] && word_idx == `IEP_IDX_G1_ENL)
        |=> s_q.g1_enl == ($past(WRITEDATA[7:0]) & ~`IEP_DAC_MASK)
    ) else $error("group 1 low enable not written");

    ctrl_write_a: assert property (
        (WRITE && !WAITREQUEST && BYTEENABLE[0] && word_idx == `IEP_IDX_CTRL)
        |=> s_q.gie == $past(WRITEDATA[`IEP_CTRL_GIE_BIT])
    ) else $error("global enable not written");

    lane_off_a: assert property (
        (WRITE && !WAITREQUEST && !BYTEENABLE[0])
        |=> $stable(s_q.g0_enl) && $stable(s_q.g1_enh) && $stable(s_q.g1_enl)
            && $stable(s_q.g2_enh) && $stable(s_q.gie)
    ) else $error("write with lane 0 off changed a register");

    g2_enable_write_a: assert property (
        (WRITE && !WAITREQUEST && BYTEENABLE[0] && word_idx == `IEP_IDX_G2_ENH)
        |=> s_q.g2_enh == $past(WRITEDATA[7:0])
    ) else $error("group 2 high enable not written");

    request_sets_a: assert property (
        (G1_REQ != 8'h00) |=> ((s_q.req1 & $past(G1_REQ)) == $past(G1_REQ))
    ) else $error("group 1 request lost");

    request_clear_a: assert property (
        (WRITE && !WAITREQUEST && BYTEENABLE[0] && word_idx == `IEP_IDX_G1_REQ
            && G1_REQ == 8'h00)
        |=> (s_q.req1 & $past(WRITEDATA[7:0])) == 8'h00
    ) else $error("group 1 request not cleared");

    source_select_a: assert property (
        (sel_req != 5'h00) |=> ((s_q.req2[4:0] & $past(sel_req)) == $past(sel_req))
    ) else $error("selected shared source not captured");

    deselect_ignored_a: assert property (
        (s_q.req2[4:0] == 5'h00 && sel_req == 5'h00) |=> s_q.req2[4:0] == 5'h00
    ) else $error("deselected shared source captured");

    polled_quiet_a: assert property (
        !s_q.gie [*2] |-> !IRQ && VEC_LEVEL == 2'h0
    ) else $error("interrupt forwarded while globally disabled");

    group0_level_a: assert property (
        (IRQ && VEC_GROUP == 2'h0) |-> VEC_LEVEL == `IEP_LVL_GROUP0
    ) else $error("group 0 winner at wrong level");

    group2_level_a: assert property (
        (IRQ && VEC_GROUP == 2'h2) |-> VEC_LEVEL == `IEP_LVL_GROUP2
    ) else $error("group 2 winner at wrong level");

    level_wins_a: assert property (
        (s_q.gie && lvl1 == 2'h3 && s_q.st == s_d.st) |=> IRQ && VEC_LEVEL == 2'h3
    ) else $error("level 3 request not chosen");

    bus_answer_a: assert property (
        (s_q.st == iep_pkg::BUS_IDLE && (READ || WRITE))
        |=> !WAITREQUEST ##1 WAITREQUEST
    ) else $error("bus answer not one cycle wide");

    irq_forward_a: assert property (
        (s_q.gie && (lvl0 != 2'h0 || lvl1 != 2'h0 || lvl2 != 2'h0)) |=> IRQ
    ) else $error("enabled request not forwarded");

    idle_vector_a: assert property (
        !IRQ |-> VEC_GROUP == 2'h0 && VEC_BIT == 3'h0 && VEC_LEVEL == 2'h0
    ) else $error("vector not cleared while idle");

    level_order_a: assert property (
        s_q.gie |=> VEC_LEVEL >= $past(lvl0) && VEC_LEVEL >= $past(lvl1)
            && VEC_LEVEL >= $past(lvl2)
    ) else $error("lower level chosen over a higher one");

    upper_zero_a: assert property (
        !WAITREQUEST |-> READDATA[31:8] == 24'h000000
    ) else $error("read data upper bits not zero");

    level3_cov: cover property (IRQ && VEC_LEVEL == 2'h3);
    polled_cov: cover property (!s_q.gie && s_q.req1 != 8'h00);
    write_cov: cover property (WRITE && !WAITREQUEST);
    porta_d_cov: cover property (IRQ && VEC_GROUP == 2'h2 && PORTD_SEL != 5'h00);

endmodule : iep_regs

`default_nettype wire

// ### bench/iep_src_model.sv
// Purpose: interrupt sources on the far side of the enable block
// Assumes: a source request is a one-cycle high pulse
// Notes: fire selects one source; alt picks the port D pin for group 2
`timescale 1ns/100ps
`default_nettype none

module iep_src_model (
    // clock
    input wire logic clk,
    // command from the bench
    input wire logic fire,
    input wire logic [1:0] grp,
    input wire logic [2:0] pos,
    input wire logic alt,
    // source lines
    output var logic [7:0] g0,
    output var logic [7:0] g1,
    output var logic [7:0] g2,
    output var logic [4:0] pd
);
    initial begin
        g0 = 8'h00;
        g1 = 8'h00;
        g2 = 8'h00;
        pd = 5'h00;
    end

    // one pulse only, so every request bit shows the set edge itself
    always @(posedge clk) begin
        g0 <= 8'h00;
        g1 <= 8'h00;
        g2 <= 8'h00;
        pd <= 5'h00;
        if (fire) begin
            case (grp)
                2'h0: g0[pos] <= 1'b1;
                2'h1: g1[pos] <= 1'b1;
                default: begin
                    if (alt) begin
                        pd[pos] <= 1'b1;
                    end else begin
                        g2[pos] <= 1'b1;
                    end
                end
            endcase
        end
    end
endmodule : iep_src_model

`default_nettype wire

// ### bench/tb.sv
// Purpose: bench for the enable and priority registers
// Assumes: one bus access at a time
// Notes: bus values taken at the rising edge that sees waitrequest low
`timescale 1ns/100ps
`default_nettype none
`include "iep_params.svh"

module tb;
    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    logic [13:0] address = 14'h0000;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] wdata = 32'h0000_0000;
    logic [3:0] be = 4'hF;
    logic [31:0] rdata;
    logic waitreq;
    logic [7:0] g0, g1, g2, q;
    logic [4:0] pd;
    logic [4:0] pd_sel = 5'h00;
    logic irq;
    logic [1:0] vgrp, vlvl;
    logic [2:0] vbit;
    logic fire = 1'b0;
    logic [1:0] f_grp = 2'h0;
    logic [2:0] f_pos = 3'h0;
    logic f_alt = 1'b0;
    int n_fail = 0;
    int n_compared = 0;
    logic [11:0] idx_tab [4] = '{`IEP_IDX_G0_ENL, `IEP_IDX_G1_ENH,
        `IEP_IDX_G1_ENL, `IEP_IDX_G2_ENH};
    logic [7:0] ones_tab [4] = '{8'hFF, 8'hBF, 8'hBF, 8'hFF};

    always #5 ref_clk = ~ref_clk;

    iep_regs iep_regs_i (.REF_CLK(ref_clk), .RESET(reset), .ADDRESS(address), .READ(rd),
        .WRITE(wr), .BYTEENABLE(be), .WRITEDATA(wdata), .READDATA(rdata),
        .WAITREQUEST(waitreq), .G0_REQ(g0), .G1_REQ(g1), .G2_REQ(g2), .PORTD_REQ(pd),
        .PORTD_SEL(pd_sel), .IRQ(irq), .VEC_GROUP(vgrp), .VEC_BIT(vbit), .VEC_LEVEL(vlvl));

    iep_src_model iep_src_model_i (.clk(ref_clk), .fire(fire), .grp(f_grp), .pos(f_pos),
        .alt(f_alt), .g0(g0), .g1(g1), .g2(g2), .pd(pd));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic stop_test();
        $display("compared %0d mismatched %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : stop_test

    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    // request held until the edge that sees waitrequest low
    // read right at the edge: the slave's flops have not moved yet
    task automatic acc(input logic w, input logic [11:0] idx, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge ref_clk);
        address <= {idx, 2'b00};
        wr <= w;
        rd <= ~w;
        wdata <= {24'h000000, d};
        do begin
            @(posedge ref_clk);
            n++;
        end while (waitreq !== 1'b0 && n < 50);
        q = rdata[7:0];
        wr <= 1'b0;
        rd <= 1'b0;
        if (n >= 50) begin
            n_fail++;
            stop_test();
        end
    endtask : acc

    task automatic pulse(input logic [1:0] g, input logic [2:0] p, input logic a);
        @(posedge ref_clk);
        fire <= 1'b1;
        f_grp <= g;
        f_pos <= p;
        f_alt <= a;
        @(posedge ref_clk);
        fire <= 1'b0;
        repeat (4) @(posedge ref_clk);
        @(negedge ref_clk);
    endtask : pulse

    task automatic vec(input logic i, input logic [1:0] g, input logic [2:0] b,
        input logic [1:0] l);
        chk("irq", {7'h00, irq}, {7'h00, i});
        chk("vector group", {6'h00, vgrp}, {6'h00, g});
        chk("vector bit", {5'h00, vbit}, {5'h00, b});
        chk("vector level", {6'h00, vlvl}, {6'h00, l});
    endtask : vec

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (12) @(posedge ref_clk);
        reset <= 1'b0;
        for (int i = 0; i < 4; i++) begin
            acc(1'b0, idx_tab[i], 8'h00);
            chk("reset value", q, 8'h00);
            acc(1'b1, idx_tab[i], 8'hFF);
            acc(1'b0, idx_tab[i], 8'h00);
            chk("all ones", q, ones_tab[i]);
            acc(1'b1, idx_tab[i], 8'h00);
        end
        acc(1'b1, 12'hFC3, 8'hFF);
        acc(1'b0, 12'hFC3, 8'h00);
        chk("unmapped", q, 8'h00);
        be <= 4'hE;
        acc(1'b1, `IEP_IDX_G2_ENH, 8'hFF);
        be <= 4'hF;
        acc(1'b0, `IEP_IDX_G2_ENH, 8'h00);
        chk("lane 0 off", q, 8'h00);
        $display("registers done");
        // every enable pair on the adc source
        acc(1'b1, `IEP_IDX_CTRL, 8'h01);
        acc(1'b0, `IEP_IDX_CTRL, 8'h00);
        chk("global enable", q, 8'h01);
        for (int c = 0; c < 4; c++) begin
            acc(1'b1, `IEP_IDX_G1_ENH, c[1] ? 8'h08 : 8'h00);
            acc(1'b1, `IEP_IDX_G1_ENL, c[0] ? 8'h08 : 8'h00);
            pulse(2'h1, 3'h3, 1'b0);
            vec(c != 0, (c != 0) ? 2'h1 : 2'h0, (c != 0) ? 3'h3 : 3'h0, c[1:0]);
            acc(1'b1, `IEP_IDX_G1_REQ, 8'h08);
        end
        $display("levels done");
        acc(1'b1, `IEP_IDX_G1_ENH, 8'h01);
        acc(1'b1, `IEP_IDX_G1_ENL, 8'h00);
        acc(1'b1, `IEP_IDX_G0_ENL, 8'h80);
        acc(1'b1, `IEP_IDX_G2_ENH, 8'h04);
        @(posedge ref_clk);
        pd_sel <= 5'h04;
        pulse(2'h0, 3'h7, 1'b0);
        vec(1'b1, 2'h0, 3'h7, 2'h1);
        acc(1'b0, `IEP_IDX_G0_REQ, 8'h00);
        chk("group0 request", q, 8'h80);
        pulse(2'h2, 3'h2, 1'b1);
        pulse(2'h1, 3'h0, 1'b0);
        vec(1'b1, 2'h1, 3'h0, 2'h2);
        acc(1'b0, `IEP_IDX_VEC, 8'h00);
        chk("vector status", q, 8'h91);
        acc(1'b1, `IEP_IDX_G1_REQ, 8'h01);
        repeat (3) @(negedge ref_clk);
        vec(1'b1, 2'h2, 3'h2, 2'h2);
        acc(1'b1, `IEP_IDX_G2_REQ, 8'h04);
        pulse(2'h2, 3'h2, 1'b0);
        acc(1'b0, `IEP_IDX_G2_REQ, 8'h00);
        chk("deselected pin", q, 8'h00);
        acc(1'b1, `IEP_IDX_G0_REQ, 8'h80);
        $display("priority done");
        // polling: requests still land, nothing forwarded
        acc(1'b1, `IEP_IDX_CTRL, 8'h00);
        acc(1'b1, `IEP_IDX_G1_ENH, 8'h08);
        pulse(2'h1, 3'h3, 1'b0);
        vec(1'b0, 2'h0, 3'h0, 2'h0);
        acc(1'b0, `IEP_IDX_G1_REQ, 8'h00);
        chk("polled request", q, 8'h08);
        $display("polling done");
        // mid-run reset clears pending requests and enables
        @(posedge ref_clk);
        reset <= 1'b1;
        repeat (2) @(posedge ref_clk);
        reset <= 1'b0;
        acc(1'b0, `IEP_IDX_G1_REQ, 8'h00);
        chk("request after reset", q, 8'h00);
        acc(1'b0, `IEP_IDX_G1_ENH, 8'h00);
        chk("enable after reset", q, 8'h00);
        vec(1'b0, 2'h0, 3'h0, 2'h0);
        $display("reset done");
        stop_test();
    end

    // run needs well under a thousand cycles
    initial begin
        repeat (20000) @(posedge ref_clk);
        n_fail++;
        stop_test();
    end
endmodule : tb

`default_nettype wire
